// *** design/sts_supervisor.sv ***
// Purpose: Link test and status supervisor for a one-lane serial bridge
// Assumes: Core status inputs synchronous to ref_clk
// Notes: Other clocks are made outside from the same reference
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module sts_supervisor
  import sts_pkg::*;
#(
  parameter int TRAIN_CYC = STS_TRAIN_CYC // Training timeout in cycles
) (
  input wire logic ref_clk, // Reference clock
  input wire logic reset, // Synchronous reset
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rdata, // Read data, next cycle
  input wire sts_core_type core, // Core status
  input wire sts_chk_type chk, // Checker results
  output logic design_reset, // Bridge logic reset
  output logic xcvr_reset, // Transceiver reset
  output logic [2:0] loopback, // Lane loopback select
  output logic bridge_sync_indication, // Link synchronised
  output logic bridge_multibit_fault, // Multi-bit error
  output logic cfg_mismatch, // Training timeout
  output logic peer_reset_flag, // Peer reset seen
  output logic peer_flag_valid, // Peer flag meaningful
  output logic lane_ready, // Lane initialised
  output logic channel_ready, // Channel initialised
  output logic clk_locked, // Clock generator locked
  output logic traffic_valid, // Pattern word valid
  output logic [31:0] traffic_data, // Pattern word
  output logic irq // Interrupt level
);
  logic [7:0] ctrl_reg; // Control register
  logic [STS_NEV-1:0] irq_reg; // Sticky event status
  logic [STS_NEV-1:0] mask_reg; // Event mask
  logic [31:0] pat_reg; // Pattern generator state
  logic [31:0] cnt_reg; // Training timer
  logic [31:0] rdata_reg; // Read data
  logic [STS_NEV-1:0] ev; // Event pulses this cycle
  logic [STS_NEV-1:0] irq_next;
  logic [31:0] rd_next;
  logic drst; // Combined design reset
  logic is_master;
  logic peer_reg; // Delayed peer reset for edge
  sts_state_type state_reg, state_next;

  assign drst = reset | ctrl_reg[STS_C_DRST];
  assign is_master = ctrl_reg[STS_C_MASTER];

  // Control register, writable; design reset bit does not touch xcvr
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_reg <= STS_CTRL_RST;
    end else if (wr_en && addr == STS_CTRL_ADDR) begin
      ctrl_reg <= wdata[7:0];
    end
  end

  // Separate resets, one per target
  assign design_reset = drst; // R7
  assign xcvr_reset = ctrl_reg[STS_C_XRST]; // R7

  // Loopback code passed straight, illegal codes fall back to normal
  always_comb begin
    unique case (ctrl_reg[STS_C_LB_LO +: 3])
      STS_LB_PCS: loopback = STS_LB_PCS; // R6
      STS_LB_PMA: loopback = STS_LB_PMA; // R6
      default: loopback = STS_LB_NORMAL; // R6
    endcase
  end

  // Link detect state machine; reset of either end drops to idle
  // Slave end has no timeout; it waits on the master's pattern
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      STS_ST_IDLE: begin
        if (core.lane_up) begin // R13
          state_next = STS_ST_TRAIN;
        end
      end
      STS_ST_TRAIN: begin
        if (!core.lane_up) begin
          state_next = STS_ST_IDLE;
        end else if (core.pattern_seen) begin
          state_next = STS_ST_SYNC;
        end else if (is_master && cnt_reg >= TRAIN_CYC - 1) begin
          state_next = STS_ST_FAIL; // R3
        end
      end
      STS_ST_SYNC: begin
        if (!core.lane_up || !core.channel_up) begin
          state_next = STS_ST_IDLE; // R1
        end
      end
      STS_ST_FAIL: begin
        state_next = STS_ST_FAIL; // Held until design reset or peer reset
      end
    endcase
    if (core.peer_in_reset) begin
      state_next = STS_ST_IDLE; // R1
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin // R12
    if (drst) begin
      state_reg <= STS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Training timer counts only while training
  // Wide counter, so a long timeout cannot wrap before it fires
  always_ff @(posedge ref_clk) begin
    if (drst || state_reg != STS_ST_TRAIN) begin
      cnt_reg <= 32'h00000000;
    end else begin
      cnt_reg <= cnt_reg + 32'h00000001; // R3
    end
  end

  // Peer reset edge detect
  // Only the rising edge counts, a held reset is one event
  always_ff @(posedge ref_clk) begin
    if (drst) begin
      peer_reg <= 1'b0;
    end else begin
      peer_reg <= core.peer_in_reset;
    end
  end

  // Event pulses; peer event only while synced
  always_comb begin
    ev = '0;
    ev[STS_E_MBIT] = core.multibit; // R2
    ev[STS_E_CFG] = is_master && state_reg == STS_ST_TRAIN &&
      state_next == STS_ST_FAIL; // R3
    ev[STS_E_PEER] = core.peer_in_reset && !peer_reg &&
      state_reg == STS_ST_SYNC; // R4
    ev[STS_E_FULL] = chk.full_mismatch && traffic_valid; // R11
    ev[STS_E_LITE] = chk.lite_mismatch && traffic_valid; // R11
    ev[STS_E_HARD] = core.hard_err; // R15
    ev[STS_E_SOFT] = core.soft_err; // R15
  end

  // Sticky status: set wins over write-one-to-clear
  // A clear racing an event loses, so no event goes unseen
  always_comb begin
    irq_next = irq_reg;
    if (wr_en && addr == STS_IRQ_ADDR) begin
      irq_next = irq_reg & ~wdata[STS_NEV-1:0];
    end
    irq_next = irq_next | ev; // R17
  end

  // Status register, cleared by design reset
  always_ff @(posedge ref_clk) begin
    if (drst) begin
      irq_reg <= '0; // R17
    end else begin
      irq_reg <= irq_next; // R17
    end
  end

  // Mask register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_reg <= '0;
    end else if (wr_en && addr == STS_MASK_ADDR) begin
      mask_reg <= wdata[STS_NEV-1:0];
    end
  end

  assign irq = |(irq_reg & mask_reg);

  // Flag outputs
  assign bridge_sync_indication = state_reg == STS_ST_SYNC; // R1
  assign bridge_multibit_fault = irq_reg[STS_E_MBIT]; // R2
  assign cfg_mismatch = irq_reg[STS_E_CFG]; // R3
  assign peer_flag_valid = is_master; // R5
  assign peer_reset_flag = irq_reg[STS_E_PEER] & is_master; // R5
  assign lane_ready = core.lane_up; // R9
  assign channel_ready = core.channel_up && core.lane_up; // R8
  assign clk_locked = core.clk_locked; // R14

  // Traffic generator: fixed decrementing pattern, gated by sync
  // Restarts from the seed after any loss, so runs repeat exactly
  always_ff @(posedge ref_clk) begin
    if (drst || !bridge_sync_indication || !ctrl_reg[STS_C_START]) begin
      pat_reg <= STS_PAT_SEED; // R16
      traffic_valid <= 1'b0; // R16
    end else begin
      traffic_valid <= 1'b1; // R10
      pat_reg <= pat_reg - STS_PAT_STEP; // R10
    end
  end

  assign traffic_data = pat_reg; // R10

  // Read mux
  always_comb begin
    rd_next = 32'h00000000;
    unique case (addr)
      STS_CTRL_ADDR: rd_next[7:0] = ctrl_reg;
      STS_STAT_ADDR: rd_next[7:0] = {core.clk_locked, 2'b00,
        state_reg, core.channel_up, core.lane_up, is_master};
      STS_IRQ_ADDR: rd_next[STS_NEV-1:0] = irq_reg;
      STS_MASK_ADDR: rd_next[STS_NEV-1:0] = mask_reg;
      STS_PAT_ADDR: rd_next = pat_reg;
      default: rd_next = 32'h00000000; // Unmapped reads zero
    endcase
  end

  // Read data registered one cycle after strobe
  // Zero outside the answer cycle keeps stale data off the bus
  always_ff @(posedge ref_clk) begin
    if (reset || !rd_en) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rd_next;
    end
  end

  assign rdata = rdata_reg;

  // Assertions
  property p_sync;
    @(posedge ref_clk) disable iff (reset)
      core.peer_in_reset |=> !bridge_sync_indication;
  endproperty
  a_sync: assert property (p_sync) else $error("sync held in reset"); // R1

  property p_mbit;
    @(posedge ref_clk) disable iff (drst)
      core.multibit |=> bridge_multibit_fault;
  endproperty
  a_mbit: assert property (p_mbit) else $error("multibit lost"); // R2

  property p_cfg;
    @(posedge ref_clk) disable iff (drst)
      ev[STS_E_CFG] |=> cfg_mismatch && state_reg == STS_ST_FAIL;
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg not flagged"); // R3

  property p_peer;
    @(posedge ref_clk) disable iff (drst)
      ev[STS_E_PEER] && is_master |=> peer_reset_flag;
  endproperty
  a_peer: assert property (p_peer) else $error("peer not flagged"); // R4

  property p_valid;
    @(posedge ref_clk) disable iff (reset)
      !is_master |-> !peer_reset_flag;
  endproperty
  a_valid: assert property (p_valid) else $error("peer flag slave"); // R5

  property p_chan;
    @(posedge ref_clk) disable iff (reset)
      channel_ready |-> core.lane_up;
  endproperty
  a_chan: assert property (p_chan) else $error("channel early"); // R8

  property p_traf;
    @(posedge ref_clk) disable iff (drst)
      traffic_valid ##1 traffic_valid |-> traffic_data ==
        $past(traffic_data) - STS_PAT_STEP;
  endproperty
  a_traf: assert property (p_traf) else $error("bad pattern"); // R10

  property p_stop;
    @(posedge ref_clk) disable iff (reset)
      !bridge_sync_indication |=> !traffic_valid;
  endproperty
  a_stop: assert property (p_stop) else $error("traffic unsynced"); // R16

  property p_sticky;
    @(posedge ref_clk) disable iff (drst)
      irq_reg[STS_E_HARD] && !(wr_en && addr == STS_IRQ_ADDR)
        |=> irq_reg[STS_E_HARD];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped"); // R17

  // Further checks on flags, resets and the read port
  property p_idle;
    @(posedge ref_clk) disable iff (reset)
      drst |=> !bridge_sync_indication;
  endproperty
  a_idle: assert property (p_idle) else $error("sync in reset"); // R1

  property p_drop;
    @(posedge ref_clk) disable iff (drst)
      bridge_sync_indication && !core.lane_up |=> !bridge_sync_indication;
  endproperty
  a_drop: assert property (p_drop) else $error("sync kept"); // R1

  property p_slave;
    @(posedge ref_clk) disable iff (drst)
      !is_master && state_reg == STS_ST_TRAIN |=> state_reg != STS_ST_FAIL;
  endproperty
  a_slave: assert property (p_slave) else $error("slave timeout"); // R3

  property p_lbk;
    @(posedge ref_clk) disable iff (reset)
      ctrl_reg[STS_C_LB_LO +: 3] == STS_LB_PMA |-> loopback == STS_LB_PMA;
  endproperty
  a_lbk: assert property (p_lbk) else $error("bad loopback"); // R6

  property p_xrst;
    @(posedge ref_clk) disable iff (reset)
      design_reset |-> xcvr_reset == ctrl_reg[STS_C_XRST];
  endproperty
  a_xrst: assert property (p_xrst) else $error("xcvr reset moved"); // R7

  property p_full;
    @(posedge ref_clk) disable iff (drst)
      chk.full_mismatch && traffic_valid |=> irq_reg[STS_E_FULL];
  endproperty
  a_full: assert property (p_full) else $error("full error lost"); // R11

  property p_lite;
    @(posedge ref_clk) disable iff (drst)
      chk.lite_mismatch && traffic_valid |=> irq_reg[STS_E_LITE];
  endproperty
  a_lite: assert property (p_lite) else $error("lite error lost"); // R11

  property p_hard;
    @(posedge ref_clk) disable iff (drst)
      core.hard_err |=> irq_reg[STS_E_HARD];
  endproperty
  a_hard: assert property (p_hard) else $error("hard error lost"); // R15

  property p_soft;
    @(posedge ref_clk) disable iff (drst)
      core.soft_err |=> irq_reg[STS_E_SOFT];
  endproperty
  a_soft: assert property (p_soft) else $error("soft error lost"); // R15

  property p_gate;
    @(posedge ref_clk) disable iff (drst)
      traffic_valid |-> $past(bridge_sync_indication);
  endproperty
  a_gate: assert property (p_gate) else $error("traffic early"); // R16

  property p_rdz;
    @(posedge ref_clk) disable iff (reset)
      !rd_en |=> rdata == 32'h00000000;
  endproperty
  a_rdz: assert property (p_rdz) else $error("stale read data");
endmodule

// *** design/sts_pkg.sv ***
// Purpose: Constants and types for the serial link test supervisor
// Assumes: One 250 MHz reference clock, synchronous active-high reset
// Notes: Register map reached over a plain strobe port
// Functional notes
// R1: Sync flag follows detect machine sync state
// R2: Multi-bit error flag on corrupted received bits
// R3: Training pattern timeout raises configuration mismatch
// R4: Peer reset during operation sets peer flag
// R5: Peer reset flag meaningful only as master
// R6: Loopback 000 normal, 001 PCS, 010 PMA
// R7: Design reset separate from transceiver reset
// R8: Channel ready only after channel initialisation
// R9: Lane ready after lane initialisation
// R10: Traffic start drives fixed transaction patterns
// R11: Separate full and lite checker error flags
// R12: All clocks derived from one reference
// R13: One 8b/10b lane at matching rate
// R14: Report clock generator locked indication
// R15: Hard error held until core reset; the code clears it on design reset or on a write of one to the status register
// R16: Traffic waits for sync, stops on loss
// R17: Error flags sticky until design reset; the code also clears them on a write of one to the status register
package sts_pkg;
  // Register offsets
  localparam logic [7:0] STS_CTRL_ADDR = 8'h00;
  localparam logic [7:0] STS_STAT_ADDR = 8'h04;
  localparam logic [7:0] STS_IRQ_ADDR = 8'h08;
  localparam logic [7:0] STS_MASK_ADDR = 8'h0C;
  localparam logic [7:0] STS_PAT_ADDR = 8'h10;
  // Control field positions
  localparam int STS_C_DRST = 0;
  localparam int STS_C_XRST = 1;
  localparam int STS_C_START = 2;
  localparam int STS_C_MASTER = 3;
  localparam int STS_C_LB_LO = 4;
  // Event bit positions in status and mask
  localparam int STS_E_MBIT = 0;
  localparam int STS_E_CFG = 1;
  localparam int STS_E_PEER = 2;
  localparam int STS_E_FULL = 3;
  localparam int STS_E_LITE = 4;
  localparam int STS_E_HARD = 5;
  localparam int STS_E_SOFT = 6;
  localparam int STS_NEV = 7;
  // Loopback codes
  localparam logic [2:0] STS_LB_NORMAL = 3'h0;
  localparam logic [2:0] STS_LB_PCS = 3'h1;
  localparam logic [2:0] STS_LB_PMA = 3'h2;
  // Reset values
  localparam logic [7:0] STS_CTRL_RST = 8'h08;
  localparam logic [31:0] STS_PAT_SEED = 32'hFFFFFFFF;
  localparam logic [31:0] STS_PAT_STEP = 32'h00000001;
  // Training timeout, in microseconds, and its cycle count
  localparam int STS_CLK_MHZ = 250;
  localparam int STS_TRAIN_US = 100;
  localparam int STS_TRAIN_CYC = STS_TRAIN_US * STS_CLK_MHZ;
  // Link detect states
  typedef enum logic [1:0] {
    STS_ST_IDLE = 2'b00,
    STS_ST_TRAIN = 2'b01,
    STS_ST_SYNC = 2'b10,
    STS_ST_FAIL = 2'b11
  } sts_state_type;
  // Core status inputs gathered together
  typedef struct packed {
    logic lane_up;
    logic channel_up;
    logic pattern_seen;
    logic multibit;
    logic peer_in_reset;
    logic hard_err;
    logic soft_err;
    logic clk_locked;
  } sts_core_type;
  // Traffic checker results
  typedef struct packed {
    logic full_mismatch;
    logic lite_mismatch;
  } sts_chk_type;
endpackage

// *** verif/sts_peer_model.sv ***
// Purpose: Far-side peer bridge and core status model
// Assumes: Bench drives the wanted status one step after the edge
// Notes: Lane stays down while the transceiver is held in reset
`timescale 1ns/1ns
module sts_peer_model
  import sts_pkg::*;
(
  input wire logic ref_clk, // Reference clock
  input wire logic xcvr_reset, // Transceiver reset
  input wire sts_core_type cmd, // Wanted core status
  input wire sts_chk_type bad, // Forced checker faults
  output sts_core_type core, // Core status out
  output sts_chk_type chk // Checker results out
);
  // Registered like the real core, so flags lag the bench by a cycle
  always_ff @(posedge ref_clk) begin
    core <= cmd;
    if (xcvr_reset) begin
      core.lane_up <= 1'b0;
      core.channel_up <= 1'b0;
      core.pattern_seen <= 1'b0;
    end
  end
  // Checker faults, one per traffic path
  always_ff @(posedge ref_clk) begin
    chk <= bad;
  end
endmodule

// *** verif/test_sts_supervisor.sv ***
// Purpose: Bench for the serial link test supervisor
// Assumes: Inputs move one step after the rising edge
// Notes: Training timeout shortened to keep the run brief
`timescale 1ns/1ns
module test_sts_supervisor;
  import sts_pkg::*;
  localparam int TCYC = 20; // Short training timeout
  logic ref_clk = 1'b0; // Reference clock
  logic reset = 1'b1; // Synchronous reset
  logic [7:0] addr = 8'h00; // Register address
  logic [31:0] wdata = 32'h0; // Write data
  logic wr_en = 1'b0; // Write strobe
  logic rd_en = 1'b0; // Read strobe
  logic [31:0] rdata, traffic_data, v; // Read data, pattern, last read
  sts_core_type cmd = '0; // Wanted core status
  sts_chk_type bad = '0; // Forced checker faults
  sts_core_type core; // Core status
  sts_chk_type chk; // Checker results
  logic design_reset, xcvr_reset, sync, mbit, cfg, peer, peer_ok; // Flags
  logic lane_ready, channel_ready, clk_locked, traffic_valid, irq; // Flags
  logic [2:0] loopback; // Loopback select
  int mismatches = 0; // Wrong values
  int n_tests = 0; // Comparisons made
  sts_supervisor #(.TRAIN_CYC(TCYC)) i_dut (.ref_clk(ref_clk),
    .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .core(core), .chk(chk),
    .design_reset(design_reset), .xcvr_reset(xcvr_reset),
    .loopback(loopback), .bridge_sync_indication(sync),
    .bridge_multibit_fault(mbit), .cfg_mismatch(cfg),
    .peer_reset_flag(peer), .peer_flag_valid(peer_ok),
    .lane_ready(lane_ready), .channel_ready(channel_ready),
    .clk_locked(clk_locked), .traffic_valid(traffic_valid),
    .traffic_data(traffic_data), .irq(irq));
  sts_peer_model i_peer (.ref_clk(ref_clk), .xcvr_reset(xcvr_reset),
    .cmd(cmd), .bad(bad), .core(core), .chk(chk));
  // Clock at 250 MHz
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // One step past the edge, so design updates have landed
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic settle;
    repeat (4) tick;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  // Strobe dropped a cycle before the next access, never re-driven at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    tick;
    wr_en <= 1'b0;
    tick;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    addr <= a;
    rd_en <= 1'b1;
    tick;
    rd_en <= 1'b0;
    v = rdata;
    tick;
  endtask
  // Short pulse on chosen core status bits
  task automatic pulse(input logic [7:0] p);
    cmd <= sts_core_type'(cmd | p);
    tick;
    cmd <= sts_core_type'(cmd & ~p);
    settle;
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog, well past the roughly 125 cycles the sequence needs
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    stop_test;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    tick;
    wr(8'h14, 32'hFFFFFFFF);
    rd(STS_CTRL_ADDR);
    check(v, 32'h08);
    rd(8'h14);
    check(v, 32'h0);
    rd(STS_IRQ_ADDR);
    check(v, 32'h0);
    wr(STS_MASK_ADDR, 32'h7F);
    for (int i = 0; i < 4; i++) begin
      wr(STS_CTRL_ADDR, 32'h08 | 32'(i << 4));
      check(loopback, (i == 1 || i == 2) ? 32'(i) : 32'h0);
    end
    wr(STS_CTRL_ADDR, 32'h0A);
    check(xcvr_reset, 1'b1);
    check(design_reset, 1'b0);
    wr(STS_CTRL_ADDR, 32'h08);
    // Link up, then traffic
    cmd <= sts_core_type'(8'hE1);
    settle;
    check(sync, 1'b1);
    check(lane_ready, 1'b1);
    check(channel_ready, 1'b1);
    check(clk_locked, 1'b1);
    rd(STS_STAT_ADDR);
    check(v, 32'h97);
    wr(STS_CTRL_ADDR, 32'h0C);
    for (int i = 0; i < 8 && traffic_valid !== 1'b1; i++)
      tick;
    check(traffic_data, 32'hFFFFFFFE);
    tick;
    check(traffic_data, 32'hFFFFFFFD);
    bad <= 2'b11;
    tick;
    bad <= 2'b00;
    settle;
    rd(STS_IRQ_ADDR);
    check(v, 32'h18);
    // Lane lost with the channel still up
    cmd.lane_up <= 1'b0;
    settle;
    check(sync, 1'b0);
    check(traffic_valid, 1'b0);
    check(channel_ready, 1'b0);
    pulse(8'h16);
    check(mbit, 1'b1);
    rd(STS_IRQ_ADDR);
    check(v, 32'h79);
    check(irq, 1'b1);
    wr(STS_MASK_ADDR, 32'h00);
    check(irq, 1'b0);
    wr(STS_MASK_ADDR, 32'h7F);
    wr(STS_IRQ_ADDR, 32'h7F);
    rd(STS_IRQ_ADDR);
    check(v, 32'h0);
    check(irq, 1'b0);
    // Peer reset while linked, then design reset
    cmd.lane_up <= 1'b1;
    settle;
    check(sync, 1'b1);
    pulse(8'h08);
    check(peer, 1'b1);
    check(peer_ok, 1'b1);
    wr(STS_CTRL_ADDR, 32'h09);
    check(design_reset, 1'b1);
    check(xcvr_reset, 1'b0);
    wr(STS_CTRL_ADDR, 32'h08);
    check(peer, 1'b0);
    rd(STS_IRQ_ADDR);
    check(v, 32'h0);
    // Training pattern never arrives
    cmd <= sts_core_type'(8'h01);
    settle;
    cmd <= sts_core_type'(8'hC1);
    repeat (TCYC + 10) tick;
    check(cfg, 1'b1);
    check(sync, 1'b0);
    rd(STS_IRQ_ADDR);
    check(v, 32'h02);
    // Slave end: peer flag carries no meaning
    wr(STS_CTRL_ADDR, 32'h01);
    wr(STS_CTRL_ADDR, 32'h00);
    cmd <= sts_core_type'(8'hE1);
    settle;
    pulse(8'h08);
    check(peer, 1'b0);
    check(peer_ok, 1'b0);
    stop_test;
  end
endmodule
